// ==== design/usb_legacy_pkg.sv ====
package usb_legacy_pkg;

  // ----------------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned STRB_W         = DATA_W / 8;
  localparam logic [ADDR_W-1:0] ROUTE_OFS      = 8'h64;
  localparam logic [ADDR_W-1:0] LEGCAP_OFS     = 8'h70;
  localparam logic [ADDR_W-1:0] CTLSTS_OFS     = 8'h74;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 8'h80;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFS = 8'h84;
  localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFS  = 8'h88;
  localparam logic [1:0]        ALIGN_ZERO     = 2'h0;

  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int unsigned ROUTE_W        = 7;
  localparam int unsigned ROUTE_LSB      = 1;
  localparam int unsigned ROUTE_MSB      = 7;
  localparam int unsigned PORT0_BIT      = 0;
  localparam int unsigned ROUTE_RSV_LSB  = 8;
  localparam int unsigned ROUTE_RSV_MSB  = 15;
  localparam int unsigned OS_SEM_BIT     = 24;
  localparam int unsigned FW_SEM_BIT     = 16;
  localparam int unsigned CAP_RSV_HI_LSB = 25;
  localparam int unsigned CAP_RSV_HI_MSB = 31;
  localparam int unsigned CAP_RSV_LO_LSB = 17;
  localparam int unsigned CAP_RSV_LO_MSB = 23;
  localparam int unsigned NCP_LSB        = 8;
  localparam int unsigned NCP_MSB        = 15;
  localparam int unsigned CAPID_LSB      = 0;
  localparam int unsigned CAPID_MSB      = 7;
  localparam int unsigned SMI_FLAG_BIT   = 29;
  localparam int unsigned SMI_EN_BIT     = 13;

  // ----------------------------------------------------------------------
  // Constant and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]        NEXT_CAP_PTR = 8'h00;
  localparam logic [7:0]        CAP_ID       = 8'h01;
  localparam logic [ROUTE_W-1:0] ROUTE_RST   = 7'h00;
  localparam logic [DATA_W-1:0] WORD_ZERO    = 32'h00000000;

  // ----------------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------------
  localparam int unsigned EVT_W     = 3;
  localparam int unsigned EVT_OS    = 0;
  localparam int unsigned EVT_FW    = 1;
  localparam int unsigned EVT_ROUTE = 2;

  typedef enum logic [0:0] {
    APB_IDLE   = 1'b0,
    APB_ANSWER = 1'b1
  } apb_state_t;

endpackage

// ==== design/irq_if.sv ====
`timescale 1ns/1ps
interface irq_if #(parameter int unsigned N = 3);
  logic [N-1:0] event_set;
  logic         enable_wr;
  logic         clear_wr;
  logic [N-1:0] wr_data;
  logic [N-1:0] status;
  logic [N-1:0] enable;
  logic         irq;

  modport regs (output event_set, enable_wr, clear_wr, wr_data,
                input  status, enable, irq);
  modport unit (input  event_set, enable_wr, clear_wr, wr_data,
                output status, enable, irq);
endinterface // irq_if

// ==== design/event_irq_unit.sv ====
`timescale 1ns/1ps
module event_irq_unit #(
  parameter int unsigned N = 3
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register side
  irq_if.unit      bus
);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  if (N < 1 || N > 32) begin : g_chk
    $error("event_irq_unit: N must be 1 to 32");
  end

  logic [N-1:0] status_q;
  logic [N-1:0] enable_q;
  logic         irq_q;

  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
    end else begin
      status_q <= bus.event_set |
                  (status_q & ~({N{bus.clear_wr}} & bus.wr_data));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= '0;
    end else if (bus.enable_wr) begin
      enable_q <= bus.wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & enable_q);
    end
  end

  assign bus.status = status_q;
  assign bus.enable = enable_q;
  assign bus.irq    = irq_q;

  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_q == $past(|(status_q & enable_q)))
    else $error("irq does not follow enabled status");

endmodule // event_irq_unit

// ==== design/usb_legacy_ownership_regs.sv ====
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
// Behaviour
// - Reserved bits of routing and capability registers always read zero.
// - Each set routing mask bit hands its port to the companion controller.
// - Port-0 routing bit is read-only zero; port 0 stays on the debug path.
// - Next-capability pointer reads 00h, ending the capability list.
// - Capability identifier reads 01h, marking legacy support.
// - Any OS semaphore change sets the SMI flag; writing one clears it.
// - A read/write enable gates SMI for ownership changes.
module usb_legacy_ownership_regs (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [usb_legacy_pkg::ADDR_W-1:0] paddr,
  input  wire logic [usb_legacy_pkg::DATA_W-1:0] pwdata,
  input  wire logic [usb_legacy_pkg::STRB_W-1:0] pstrb,
  output logic      [usb_legacy_pkg::DATA_W-1:0] prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Controller side
  output logic      [usb_legacy_pkg::ROUTE_W-1:0] companion_route,
  output logic                               os_owned,
  output logic                               fw_owned,
  output logic                               smi,
  output logic                               irq
);

  import usb_legacy_pkg::*;

  // ----------------------------------------------------------------------
  // Bus state
  // ----------------------------------------------------------------------
  apb_state_t           state_q;
  logic [DATA_W-1:0]    prdata_q;
  logic                 pready_q;
  logic                 pslverr_q;
  logic [DATA_W-1:0]    rdata_c;
  logic                 hit_c;
  logic [DATA_W-1:0]    wmask;
  logic                 fire;
  logic                 wr_fire;

  // Register state
  logic [ROUTE_W-1:0]   route_q;
  logic                 os_sem_q;
  logic                 fw_sem_q;
  logic                 smi_flag_q;
  logic                 smi_en_q;
  logic                 smi_q;

  logic [DATA_W-1:0]    route_word;
  logic [DATA_W-1:0]    cap_word;
  logic [DATA_W-1:0]    ctl_word;
  logic [DATA_W-1:0]    route_new;
  logic [DATA_W-1:0]    cap_new;
  logic [DATA_W-1:0]    ctl_new;
  logic                 wr_route;
  logic                 wr_cap;
  logic                 wr_ctl;
  logic                 os_change;
  logic                 fw_change;
  logic                 route_change;
  logic                 aligned;

  irq_if #(.N(EVT_W)) ev ();

  // ----------------------------------------------------------------------
  // Byte lanes
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < STRB_W; i++) begin : g_lane
    assign wmask[i*8 +: 8] = {8{pstrb[i]}};
  end

  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [DATA_W-1:0] m
  );
    merge = (new_v & m) | (old_v & ~m);
  endfunction

  // ----------------------------------------------------------------------
  // Read words
  // ----------------------------------------------------------------------
  always_comb begin
    route_word = WORD_ZERO;
    route_word[ROUTE_MSB:ROUTE_LSB] = route_q;
    route_word[PORT0_BIT] = 1'b0;
    cap_word = WORD_ZERO;
    cap_word[OS_SEM_BIT] = os_sem_q;
    cap_word[FW_SEM_BIT] = fw_sem_q;
    cap_word[NCP_MSB:NCP_LSB] = NEXT_CAP_PTR;
    cap_word[CAPID_MSB:CAPID_LSB] = CAP_ID;
    ctl_word = WORD_ZERO;
    ctl_word[SMI_FLAG_BIT] = smi_flag_q;
    ctl_word[SMI_EN_BIT] = smi_en_q;
  end

  assign aligned = (paddr[1:0] == ALIGN_ZERO);

  always_comb begin
    rdata_c = WORD_ZERO;
    hit_c   = aligned;
    case (paddr)
      ROUTE_OFS:      rdata_c = route_word;
      LEGCAP_OFS:     rdata_c = cap_word;
      CTLSTS_OFS:     rdata_c = ctl_word;
      IRQ_STATUS_OFS: rdata_c[EVT_W-1:0] = ev.status;
      IRQ_ENABLE_OFS: rdata_c[EVT_W-1:0] = ev.enable;
      IRQ_CLEAR_OFS:  rdata_c = WORD_ZERO;
      default:        hit_c = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------------
  // One wait state buys registered read data and error
  assign fire    = psel && penable && pready_q;
  assign wr_fire = fire && pwrite && !pslverr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= APB_IDLE;
      pready_q  <= 1'b0;
      prdata_q  <= WORD_ZERO;
      pslverr_q <= 1'b0;
    end else begin
      case (state_q)
        APB_IDLE: begin
          if (psel && penable) begin
            state_q   <= APB_ANSWER;
            pready_q  <= 1'b1;
            prdata_q  <= pwrite ? WORD_ZERO : rdata_c;
            pslverr_q <= !hit_c || (pwrite && paddr == IRQ_STATUS_OFS);
          end
        end
        APB_ANSWER: begin
          state_q   <= APB_IDLE;
          pready_q  <= 1'b0;
          pslverr_q <= 1'b0;
        end
        default: begin
          state_q  <= APB_IDLE;
          pready_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  assign wr_route  = wr_fire && paddr == ROUTE_OFS;
  assign wr_cap    = wr_fire && paddr == LEGCAP_OFS;
  assign wr_ctl    = wr_fire && paddr == CTLSTS_OFS;
  assign route_new = merge(route_word, pwdata, wmask);
  assign cap_new   = merge(cap_word, pwdata, wmask);
  assign ctl_new   = merge(ctl_word, pwdata, wmask);

  assign os_change    = wr_cap && (cap_new[OS_SEM_BIT] != os_sem_q);
  assign fw_change    = wr_cap && (cap_new[FW_SEM_BIT] != fw_sem_q);
  assign route_change = wr_route &&
                        (route_new[ROUTE_MSB:ROUTE_LSB] != route_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_q <= ROUTE_RST;
    end else if (wr_route) begin
      route_q <= route_new[ROUTE_MSB:ROUTE_LSB];
    end
  end

  // Semaphores are plain storage; the handoff protocol is software's
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      os_sem_q <= 1'b0;
      fw_sem_q <= 1'b0;
    end else if (wr_cap) begin
      os_sem_q <= cap_new[OS_SEM_BIT];
      fw_sem_q <= cap_new[FW_SEM_BIT];
    end
  end

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smi_flag_q <= 1'b0;
    end else if (os_change) begin
      smi_flag_q <= 1'b1;
    end else if (wr_ctl && pwdata[SMI_FLAG_BIT] && wmask[SMI_FLAG_BIT]) begin
      smi_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smi_en_q <= 1'b0;
    end else if (wr_ctl) begin
      smi_en_q <= ctl_new[SMI_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smi_q <= 1'b0;
    end else begin
      smi_q <= smi_flag_q && smi_en_q;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt unit
  // ----------------------------------------------------------------------
  always_comb begin
    ev.event_set            = '0;
    ev.event_set[EVT_OS]    = os_change;
    ev.event_set[EVT_FW]    = fw_change;
    ev.event_set[EVT_ROUTE] = route_change;
  end
  assign ev.enable_wr = wr_fire && paddr == IRQ_ENABLE_OFS && pstrb[0];
  assign ev.clear_wr  = wr_fire && paddr == IRQ_CLEAR_OFS && pstrb[0];
  assign ev.wr_data   = pwdata[EVT_W-1:0];

  event_irq_unit #(.N(EVT_W)) u_irq (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (ev)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign companion_route = route_q;
  assign os_owned        = os_sem_q;
  assign fw_owned        = fw_sem_q;
  assign smi             = smi_q;
  assign irq             = ev.irq;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  route_rsvd_zero_a: assert property (
    pready_q && !pwrite && paddr == ROUTE_OFS
    |-> prdata_q[ROUTE_RSV_MSB:ROUTE_RSV_LSB] == 8'h00)
    else $error("routing reserved bits not zero");

  cap_rsvd_zero_a: assert property (
    pready_q && !pwrite && paddr == LEGCAP_OFS
    |-> prdata_q[CAP_RSV_HI_MSB:CAP_RSV_HI_LSB] == 7'h00 &&
        prdata_q[CAP_RSV_LO_MSB:CAP_RSV_LO_LSB] == 7'h00)
    else $error("capability reserved bits not zero");

  route_mask_write_a: assert property (
    wr_fire && paddr == ROUTE_OFS && pstrb[0]
    |=> companion_route == $past(pwdata[ROUTE_MSB:ROUTE_LSB]))
    else $error("companion routing does not follow mask write");

  port0_readonly_a: assert property (
    pready_q && !pwrite && paddr == ROUTE_OFS |-> !prdata_q[PORT0_BIT])
    else $error("port 0 routing bit reads one");

  next_cap_ptr_a: assert property (
    pready_q && !pwrite && paddr == LEGCAP_OFS
    |-> prdata_q[NCP_MSB:NCP_LSB] == NEXT_CAP_PTR)
    else $error("next capability pointer wrong");

  cap_id_value_a: assert property (
    pready_q && !pwrite && paddr == LEGCAP_OFS
    |-> prdata_q[CAPID_MSB:CAPID_LSB] == CAP_ID)
    else $error("capability identifier wrong");

  smi_flag_set_a: assert property (
    os_change |=> smi_flag_q ##0 $changed(os_owned))
    else $error("ownership change did not set flag");

  smi_enable_store_a: assert property (
    wr_ctl && pstrb[1] |=> smi_en_q == $past(pwdata[SMI_EN_BIT]))
    else $error("smi enable not stored");

  smi_output_a: assert property (
    smi_flag_q && smi_en_q |=> smi)
    else $error("smi output not asserted");

  os_request_c: cover property (wr_cap && cap_new[OS_SEM_BIT] && fw_sem_q);
  handoff_c:    cover property (os_sem_q && !fw_sem_q && smi);
  irq_c:        cover property ($rose(irq));
  error_c:      cover property (pready_q && pslverr_q);

endmodule // usb_legacy_ownership_regs

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import usb_legacy_pkg::*;

  // ----------------------------------------------------------------------
  // Stimulus table
  // ----------------------------------------------------------------------
  typedef struct {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [3:0]  s;
    logic [31:0] rd;
    logic        er;
    logic [6:0]  rt;
    logic [1:0]  own;
  } row_t;

  localparam int NROWS = 14;
  localparam int LIMIT = 4000;

  logic                 pclk;
  logic                 presetn;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [ADDR_W-1:0]    paddr;
  logic [DATA_W-1:0]    pwdata;
  logic [STRB_W-1:0]    pstrb;
  logic [DATA_W-1:0]    prdata;
  logic                 pready;
  logic                 pslverr;
  logic [ROUTE_W-1:0]   companion_route;
  logic                 os_owned;
  logic                 fw_owned;
  logic                 smi;
  logic                 irq;
  logic [31:0]          rdat;
  logic                 rerr;
  int                   err_count;
  int                   cmp_count;
  int                   cyc;
  row_t                 rows [0:NROWS-1];

  usb_legacy_ownership_regs usb_legacy_ownership_regs_i (
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .pstrb           (pstrb),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .companion_route (companion_route),
    .os_owned        (os_owned),
    .fw_owned        (fw_owned),
    .smi             (smi),
    .irq             (irq)
  );

  // ----------------------------------------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Cuts a hung handshake short
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count = err_count + 1;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ----------------------------------------------------------------------
  // APB master
  // ----------------------------------------------------------------------
  // Pready read at the rising edge, before that edge's updates land
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF, rdat, rerr);
    repeat (3) @(negedge pclk);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h00000000, 4'hF, rdat, rerr);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    err_count = 0;
    cmp_count = 0;
    cyc       = 0;
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h00000000;
    pstrb     = 4'h0;
    rows = '{
      '{1'b0, ROUTE_OFS,  32'h0, 4'hF, 32'h00000000, 1'b0, 7'h00, 2'h0},
      '{1'b0, LEGCAP_OFS, 32'h0, 4'hF, 32'h00000001, 1'b0, 7'h00, 2'h0},
      '{1'b0, CTLSTS_OFS, 32'h0, 4'hF, 32'h00000000, 1'b0, 7'h00, 2'h0},
      '{1'b1, ROUTE_OFS,  32'hFFFFFFFF, 4'hF, 32'h0, 1'b0, 7'h7F, 2'h0},
      '{1'b0, ROUTE_OFS,  32'h0, 4'hF, 32'h000000FE, 1'b0, 7'h7F, 2'h0},
      '{1'b1, ROUTE_OFS,  32'h00000014, 4'hE, 32'h0, 1'b0, 7'h7F, 2'h0},
      '{1'b1, ROUTE_OFS,  32'h00000014, 4'h1, 32'h0, 1'b0, 7'h0A, 2'h0},
      '{1'b1, LEGCAP_OFS, 32'hFFFFFFFF, 4'hF, 32'h0, 1'b0, 7'h0A, 2'h3},
      '{1'b0, LEGCAP_OFS, 32'h0, 4'hF, 32'h01010001, 1'b0, 7'h0A, 2'h3},
      '{1'b1, LEGCAP_OFS, 32'h01000000, 4'hF, 32'h0, 1'b0, 7'h0A, 2'h2},
      '{1'b0, LEGCAP_OFS, 32'h0, 4'hF, 32'h01000001, 1'b0, 7'h0A, 2'h2},
      '{1'b0, 8'h68, 32'h0, 4'hF, 32'h00000000, 1'b1, 7'h0A, 2'h2},
      '{1'b0, 8'h65, 32'h0, 4'hF, 32'h00000000, 1'b1, 7'h0A, 2'h2},
      '{1'b1, IRQ_STATUS_OFS, 32'hFFFFFFFF, 4'hF, 32'h0, 1'b1, 7'h0A, 2'h2}
    };
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // Table rows: register map, strobes, semaphores, refusals
    for (int i = 0; i < NROWS; i++) begin
      xfer(rows[i].w, rows[i].a, rows[i].d, rows[i].s, rdat, rerr);
      if (!rows[i].w) begin
        chk("prdata", rdat, rows[i].rd);
      end
      chk("pslverr", {31'h0, rerr}, {31'h0, rows[i].er});
      repeat (2) @(negedge pclk);
      chk("route", {25'h0, companion_route}, {25'h0, rows[i].rt});
      chk("owner", {30'h0, os_owned, fw_owned}, {30'h0, rows[i].own});
    end
    // Ownership-change flag, its enable and the management interrupt
    rd(CTLSTS_OFS);
    chk("ctlsts", rdat, 32'h20000000);
    chk("smi", {31'h0, smi}, 32'h0);
    wr(CTLSTS_OFS, 32'h00002000);
    chk("smi", {31'h0, smi}, 32'h1);
    wr(CTLSTS_OFS, 32'h20002000);
    chk("smi", {31'h0, smi}, 32'h0);
    rd(CTLSTS_OFS);
    chk("ctlsts", rdat, 32'h00002000);
    wr(LEGCAP_OFS, 32'h00000000);
    chk("smi", {31'h0, smi}, 32'h1);
    // Event interrupt: raise, mask, clear
    rd(IRQ_STATUS_OFS);
    chk("irq_status", rdat, 32'h00000007);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(IRQ_ENABLE_OFS, 32'h00000001);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(IRQ_CLEAR_OFS, 32'h00000001);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(IRQ_ENABLE_OFS, 32'h00000004);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(IRQ_ENABLE_OFS, 32'h00000000);
    chk("irq", {31'h0, irq}, 32'h0);
    rd(IRQ_CLEAR_OFS);
    chk("irq_clear", rdat, 32'h00000000);
    rd(IRQ_STATUS_OFS);
    chk("irq_status", rdat, 32'h00000006);
    // Reset in mid-run zeroes outputs and registers; the capability ID still reads 01h
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(negedge pclk);
    chk("outputs", {21'h0, companion_route, os_owned, fw_owned, smi, irq},
        32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    rd(ROUTE_OFS);
    chk("route_reg", rdat, 32'h00000000);
    rd(LEGCAP_OFS);
    chk("legcap", rdat, 32'h00000001);
    rd(CTLSTS_OFS);
    chk("ctlsts", rdat, 32'h00000000);
    close_out();
  end

endmodule // tb_top
